// File: core/arlk_consts.vh
`ifndef ARLK_CONSTS_VH
`define ARLK_CONSTS_VH

// Register byte offsets on the APB slave.
`define ARLK_REG_CTRL 8'h00
`define ARLK_REG_SWITCH 8'h04
`define ARLK_REG_PULSE 8'h08
`define ARLK_REG_TIMES 8'h0c
`define ARLK_REG_FTDLY 8'h10
`define ARLK_REG_WEIGHT 8'h14
`define ARLK_REG_MAINT 8'h18
`define ARLK_REG_STATUS 8'h1c

// Control register field positions.
`define ARLK_CTRL_ENABLE 0
`define ARLK_CTRL_FBUSED 1
`define ARLK_CTRL_SYNCEN 2
`define ARLK_CTRL_REMOPEN 3
`define ARLK_CTRL_MANOPEN 4
`define ARLK_CTRL_FTEN 5
`define ARLK_CTRL_SHOTS_LSB 8

// Switch group bit positions (group one in [7:0], group two in [15:8]).
`define ARLK_SW1_MANCLOSE_A 5
`define ARLK_SW1_MANCLOSE_B 6
`define ARLK_SW2_MAINTBLK 13
`define ARLK_SW2_OPCOIL_A 14
`define ARLK_SW2_OPCOIL_B 15
`define ARLK_SW2_SYNC_LSB 8

// Reset values.
`define ARLK_CTRL_RST 11'h001
`define ARLK_SWITCH_RST 16'h0000
`define ARLK_PULSE_RST 32'h00c8_00c8
`define ARLK_TIMES_RST 32'h01f4_2710
`define ARLK_FTDLY_RST 32'h0000_0000
`define ARLK_WEIGHT_RST 30'h0000_0000
`define ARLK_MAINT_RST 16'h0000
`define ARLK_SHOT_RST 3'h1

// Shot pointer values.
`define ARLK_PTR_FINAL 3'h6
`define ARLK_PTR_LOCK 3'h7

// Interruption and lock-out cause codes.
`define ARLK_CAUSE_NONE 4'h0
`define ARLK_CAUSE_FAIL 4'h1
`define ARLK_CAUSE_DEADCLOSE 4'h2
`define ARLK_CAUSE_INHIBIT 4'h3
`define ARLK_CAUSE_REMOTE 4'h4
`define ARLK_CAUSE_DISABLED 4'h5
`define ARLK_CAUSE_FAULT 4'h6
`define ARLK_CAUSE_CLOSEWAIT 4'h7
`define ARLK_CAUSE_MANCLOSE 4'h8
`define ARLK_CAUSE_MAINT 4'h9
`define ARLK_CAUSE_FINAL 4'ha

// Timing: clock period and time base tick in ns, durations in ms.
`define ARLK_CLK_NS 8
`define ARLK_TICK_NS 1000000
`define ARLK_ALARM_MIN_MS 8'hc8
`define ARLK_WAIT_MS 16'h07d0
`define ARLK_WATCH_MS 17'h1d4c0

`endif

// File: core/arlk_reclose_lockout.v
// Decided for this implementation: the register offsets and the APB register port.
`timescale 1ns/1ps
`include "arlk_consts.vh"

module arlk_reclose_lockout
#(
  parameter integer TICK_CYCLES = `ARLK_TICK_NS / `ARLK_CLK_NS
)
(
  // Clock, reset and clock enable.
  input wire clk,
  input wire rst_b,
  input wire ce,
  // APB slave.
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // Pins from the protection modules and the breaker.
  input wire [3:0] reclose_initiation_lines,
  input wire breaker_position_input,
  input wire close_inhibit_input,
  input wire reclose_inhibit_input,
  input wire synchronism_input,
  input wire internal_fault,
  // Breaker control and alarms.
  output reg breaker_open,
  output reg breaker_close,
  output reg breaker_fail_alarm,
  output reg [3:0] definite_trip_alarm
);

  // Sequencer states.
  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_DEAD = 2'h1;
  localparam [1:0] ST_WAITC = 2'h2;
  localparam [1:0] ST_CLOSING = 2'h3;
  localparam integer TICK_LAST = TICK_CYCLES - 1;

  // Two-flop synchronisers for the nine pin inputs.
  reg [8:0] pin_meta_ff;
  reg [8:0] pin_sync_ff;
  // Software registers.
  reg [10:0] ctrl_ff;
  reg [15:0] switch_ff;
  reg [31:0] pulse_ff;
  reg [31:0] times_ff;
  reg [31:0] ftdly_ff;
  reg [29:0] weight_ff;
  reg [15:0] prealarm_ff;
  reg [15:0] maint_ld_ff;
  reg maint_load_ff;
  reg rem_open_ff;
  reg man_open_ff;
  // Time base.
  reg [16:0] tick_cnt_ff;
  reg tick_ff;
  // Breaker control and supervision.
  reg pos_d_ff;
  reg [15:0] pulse_cnt_ff;
  reg fail_evt_ff;
  // Sequencer.
  reg [1:0] state_ff;
  reg [2:0] ptr_ff;
  reg [2:0] shot_ff;
  reg [15:0] st_cnt_ff;
  reg seen_ff;
  reg [15:0] reclaim_cnt_ff;
  reg reclaim_run_ff;
  reg [3:0] cause_ff;
  reg close_req_ff;
  reg timeout_ff;
  // Maintenance and alarms.
  reg [15:0] maint_ff;
  reg [7:0] cbf_cnt_ff;
  reg [3:0] dt_evt_ff;
  wire [3:0] long_act;
  wire [3:0] ft_ready;

  // Synchronised pin views.
  wire [3:0] lines = pin_sync_ff[3:0];
  wire pos_s = pin_sync_ff[4];
  wire close_inhibit_input_s = pin_sync_ff[5];
  wire reclose_inhibit_input_s = pin_sync_ff[6];
  wire sync_s = pin_sync_ff[7];
  wire fault_s = pin_sync_ff[8];

  // Decoded settings.
  wire enable = ctrl_ff[`ARLK_CTRL_ENABLE];
  wire opcoil = switch_ff[`ARLK_SW2_OPCOIL_A] & switch_ff[`ARLK_SW2_OPCOIL_B];
  wire fb_used = ctrl_ff[`ARLK_CTRL_FBUSED] & ~opcoil;
  wire [2:0] shots = ctrl_ff[`ARLK_CTRL_SHOTS_LSB+2:`ARLK_CTRL_SHOTS_LSB];
  wire maint_en = |weight_ff;
  wire maint_zero = maint_en & (maint_ff == 16'h0000);
  wire any_line = |lines;
  wire [3:0] low_line = lines & (~lines + 4'h1);

  // Breaker events: in opening-coil mode the input marks a trip, not a position.
  wire open_evt = opcoil ? (pos_s & ~pos_d_ff) :
                  fb_used ? (~pos_s & pos_d_ff) : (rem_open_ff | man_open_ff);
  wire close_evt = fb_used & pos_s & ~pos_d_ff;
  wire man_close = close_evt & ~breaker_close;
  wire in_seq = (state_ff != ST_IDLE) | ((ptr_ff != 3'h1) & (ptr_ff != `ARLK_PTR_LOCK));
  wire man_close_lock = man_close & (in_seq | switch_ff[`ARLK_SW1_MANCLOSE_A] |
                                     switch_ff[`ARLK_SW1_MANCLOSE_B]);

  // Final trip fires once the lowest ready line has held for its own delay.
  wire [3:0] ft_fire_vec = ft_ready & (~ft_ready + 4'h1);
  wire ft_fire = (state_ff == ST_IDLE) & (ptr_ff == `ARLK_PTR_FINAL) & enable & (|ft_ready);
  wire open_req = ft_fire | rem_open_ff | man_open_ff;

  // Level causes keep the pointer at lock-out until they clear.
  wire lock_level = reclose_inhibit_input_s | ~enable | fault_s | (maint_zero & switch_ff[`ARLK_SW2_MAINTBLK]);

  // Close pre-conditions, with synchronism required only for enabled shots.
  wire sync_need = ctrl_ff[`ARLK_CTRL_SYNCEN] & switch_ff[`ARLK_SW2_SYNC_LSB + shot_ff - 3'h1];
  wire close_ok = ~(fb_used & pos_s) & ~any_line & ~close_inhibit_input_s &
                  ~(switch_ff[`ARLK_SW2_MAINTBLK] & maint_zero) & (~sync_need | sync_s);

  // Interruption of a running shot sequence, first match recorded.
  wire seq_run = state_ff != ST_IDLE;
  wire dead_close = (state_ff == ST_DEAD) & close_evt;
  wire abort = seq_run & (fail_evt_ff | dead_close | reclose_inhibit_input_s | rem_open_ff |
                          ~enable | fault_s | timeout_ff);
  reg [3:0] abort_cause;

  // Maintenance decrement weight: lowest active line, or manual when none.
  reg [5:0] dec_w;

  // Cause encoder and weight select.
  always @*
  begin
    abort_cause = `ARLK_CAUSE_FAULT;
    if (fail_evt_ff)
      abort_cause = `ARLK_CAUSE_FAIL;
    else if (timeout_ff)
      abort_cause = `ARLK_CAUSE_CLOSEWAIT;
    else if (dead_close)
      abort_cause = `ARLK_CAUSE_DEADCLOSE;
    else if (reclose_inhibit_input_s)
      abort_cause = `ARLK_CAUSE_INHIBIT;
    else if (rem_open_ff)
      abort_cause = `ARLK_CAUSE_REMOTE;
    else if (~enable)
      abort_cause = `ARLK_CAUSE_DISABLED;
    if (low_line[0])
      dec_w = weight_ff[5:0];
    else if (low_line[1])
      dec_w = weight_ff[11:6];
    else if (low_line[2])
      dec_w = weight_ff[17:12];
    else if (low_line[3])
      dec_w = weight_ff[23:18];
    else
      dec_w = weight_ff[29:24];
  end

  // Pin synchroniser; only the second stage is read by logic.
  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pin_meta_ff <= 9'h000;
      pin_sync_ff <= 9'h000;
    end
    else if (ce)
    begin
      pin_meta_ff <= {internal_fault, synchronism_input, reclose_inhibit_input,
                      close_inhibit_input, breaker_position_input, reclose_initiation_lines};
      pin_sync_ff <= pin_meta_ff;
    end
  end

  // Millisecond time base for every duration.
  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      tick_cnt_ff <= 17'h00000;
      tick_ff <= 1'b0;
    end
    else if (ce)
    begin
      tick_ff <= ({15'h0000, tick_cnt_ff} == TICK_LAST);
      if ({15'h0000, tick_cnt_ff} == TICK_LAST)
        tick_cnt_ff <= 17'h00000;
      else
        tick_cnt_ff <= tick_cnt_ff + 17'h00001;
    end
  end

  // APB slave: every access takes two access cycles; unmapped offsets answer with pslverr.
  wire acc_first = psel & penable & ~pready;
  wire acc_done = psel & penable & pready;
  reg [31:0] rd_mux;
  reg hit;

  // Read multiplexer; status shows the sequencer's own state.
  always @*
  begin
    hit = 1'b1;
    rd_mux = 32'h0000_0000;
    case (paddr)
      `ARLK_REG_CTRL: rd_mux = {21'h000000, ctrl_ff & 11'h727};
      `ARLK_REG_SWITCH: rd_mux = {16'h0000, switch_ff};
      `ARLK_REG_PULSE: rd_mux = pulse_ff;
      `ARLK_REG_TIMES: rd_mux = times_ff;
      `ARLK_REG_FTDLY: rd_mux = ftdly_ff;
      `ARLK_REG_WEIGHT: rd_mux = {2'h0, weight_ff};
      `ARLK_REG_MAINT: rd_mux = {prealarm_ff, maint_ff};
      `ARLK_REG_STATUS: rd_mux = {15'h0000, reclaim_run_ff, cause_ff, definite_trip_alarm,
                                  breaker_fail_alarm, maint_zero, state_ff, 1'b0, ptr_ff};
      default: hit = 1'b0;
    endcase
  end

  // Register writes take effect at the completing access edge.
  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
      ctrl_ff <= `ARLK_CTRL_RST;
      switch_ff <= `ARLK_SWITCH_RST;
      pulse_ff <= `ARLK_PULSE_RST;
      times_ff <= `ARLK_TIMES_RST;
      ftdly_ff <= `ARLK_FTDLY_RST;
      weight_ff <= `ARLK_WEIGHT_RST;
      prealarm_ff <= `ARLK_MAINT_RST;
      maint_ld_ff <= `ARLK_MAINT_RST;
      maint_load_ff <= 1'b0;
      rem_open_ff <= 1'b0;
      man_open_ff <= 1'b0;
    end
    else if (ce)
    begin
      pready <= acc_first;
      pslverr <= acc_first & ~hit;
      if (acc_first & ~pwrite & hit)
        prdata <= rd_mux;
      // Command bits are one-cycle strobes and never stored.
      maint_load_ff <= 1'b0;
      rem_open_ff <= 1'b0;
      man_open_ff <= 1'b0;
      if (acc_done & pwrite)
      begin
        case (paddr)
          `ARLK_REG_CTRL:
          begin
            ctrl_ff <= pwdata[10:0] & 11'h727;
            rem_open_ff <= pwdata[`ARLK_CTRL_REMOPEN];
            man_open_ff <= pwdata[`ARLK_CTRL_MANOPEN];
          end
          `ARLK_REG_SWITCH: switch_ff <= pwdata[15:0];
          `ARLK_REG_PULSE: pulse_ff <= pwdata;
          `ARLK_REG_TIMES: times_ff <= pwdata;
          `ARLK_REG_FTDLY: ftdly_ff <= pwdata;
          `ARLK_REG_WEIGHT: weight_ff <= pwdata[29:0];
          `ARLK_REG_MAINT:
          begin
            maint_ld_ff <= pwdata[15:0];
            prealarm_ff <= pwdata[31:16];
            maint_load_ff <= 1'b1;
          end
          default: maint_load_ff <= 1'b0;
        endcase
      end
    end
  end

  // Per-line watch counters and definite trip alarms.
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1)
    begin : g_line
      reg [16:0] watch_ff;
      reg [7:0] hold_ff;
      assign long_act[gi] = (watch_ff == `ARLK_WATCH_MS);
      assign ft_ready[gi] = lines[gi] & (watch_ff >= {9'h000, ftdly_ff[8*gi+7:8*gi]});
      // Milliseconds of continuous activity, saturating at the watch limit.
      always @(posedge clk or negedge rst_b)
      begin
        if (!rst_b)
        begin
          watch_ff <= 17'h00000;
          hold_ff <= 8'h00;
          definite_trip_alarm[gi] <= 1'b0;
        end
        else if (ce)
        begin
          if (~lines[gi])
            watch_ff <= 17'h00000;
          else if (tick_ff & ~long_act[gi])
            watch_ff <= watch_ff + 17'h00001;
          // A new event restarts the minimum hold time.
          if (dt_evt_ff[gi])
            hold_ff <= `ARLK_ALARM_MIN_MS;
          else if (tick_ff & (hold_ff != 8'h00))
            hold_ff <= hold_ff - 8'h01;
          definite_trip_alarm[gi] <= long_act[gi] | (hold_ff != 8'h00) | dt_evt_ff[gi];
        end
      end
    end
  endgenerate

  // Open and close pulse generator with position supervision.
  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      breaker_open <= 1'b0;
      breaker_close <= 1'b0;
      pulse_cnt_ff <= 16'h0000;
      fail_evt_ff <= 1'b0;
      pos_d_ff <= 1'b0;
    end
    else if (ce)
    begin
      pos_d_ff <= pos_s;
      fail_evt_ff <= 1'b0;
      if (open_req)
      begin
        // Open always wins and cuts a running close pulse.
        breaker_open <= 1'b1;
        breaker_close <= 1'b0;
        pulse_cnt_ff <= pulse_ff[15:0];
      end
      else if (close_req_ff & ~breaker_open)
      begin
        breaker_close <= 1'b1;
        pulse_cnt_ff <= pulse_ff[31:16];
      end
      else if (breaker_open | breaker_close)
      begin
        if (fb_used & (breaker_open ? ~pos_s : pos_s))
        begin
          breaker_open <= 1'b0;
          breaker_close <= 1'b0;
        end
        else if (tick_ff)
        begin
          if (pulse_cnt_ff <= 16'h0001)
          begin
            breaker_open <= 1'b0;
            breaker_close <= 1'b0;
            fail_evt_ff <= fb_used;
          end
          pulse_cnt_ff <= pulse_cnt_ff - 16'h0001;
        end
      end
    end
  end

  // Weighted maintenance down-counter; a non-zero load clears the zero alarm.
  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      maint_ff <= `ARLK_MAINT_RST;
    else if (ce)
    begin
      if (maint_load_ff)
        maint_ff <= maint_ld_ff;
      else if (open_evt & maint_en)
        maint_ff <= (maint_ff > {10'h000, dec_w}) ? maint_ff - {10'h000, dec_w} : 16'h0000;
    end
  end

  // Breaker fail alarm: permanent at zero count, otherwise a 0.2 s pulse.
  wire pre_hit = open_evt & (prealarm_ff != 16'h0000) & maint_en & (maint_ff <= prealarm_ff);
  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cbf_cnt_ff <= 8'h00;
      breaker_fail_alarm <= 1'b0;
    end
    else if (ce)
    begin
      if (fail_evt_ff | timeout_ff | pre_hit)
        cbf_cnt_ff <= `ARLK_ALARM_MIN_MS;
      else if (tick_ff & (cbf_cnt_ff != 8'h00))
        cbf_cnt_ff <= cbf_cnt_ff - 8'h01;
      breaker_fail_alarm <= maint_zero | (cbf_cnt_ff != 8'h00);
    end
  end

  // Shot sequencer, shot pointer, lock-out and reclaim timer.
  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_ff <= ST_IDLE;
      ptr_ff <= `ARLK_SHOT_RST;
      shot_ff <= `ARLK_SHOT_RST;
      st_cnt_ff <= 16'h0000;
      seen_ff <= 1'b0;
      reclaim_cnt_ff <= 16'h0000;
      reclaim_run_ff <= 1'b0;
      cause_ff <= `ARLK_CAUSE_NONE;
      close_req_ff <= 1'b0;
      timeout_ff <= 1'b0;
      dt_evt_ff <= 4'h0;
    end
    else if (ce)
    begin
      close_req_ff <= 1'b0;
      timeout_ff <= 1'b0;
      dt_evt_ff <= 4'h0;
      // Reclaim counts only once no lock-out cause remains.
      if (reclaim_run_ff & ~lock_level & tick_ff)
      begin
        if (reclaim_cnt_ff <= 16'h0001)
        begin
          reclaim_run_ff <= 1'b0;
          ptr_ff <= `ARLK_SHOT_RST;
        end
        else
          reclaim_cnt_ff <= reclaim_cnt_ff - 16'h0001;
      end
      case (state_ff)
        ST_IDLE:
        begin
          if (ft_fire)
          begin
            dt_evt_ff <= ft_fire_vec;
            ptr_ff <= `ARLK_PTR_LOCK;
            cause_ff <= `ARLK_CAUSE_FINAL;
            reclaim_cnt_ff <= times_ff[15:0];
            reclaim_run_ff <= 1'b1;
          end
          else if (open_evt & any_line)
          begin
            if (enable & (ptr_ff != 3'h0) & (ptr_ff <= shots) & (ptr_ff < `ARLK_PTR_FINAL))
            begin
              state_ff <= ST_DEAD;
              shot_ff <= ptr_ff;
              st_cnt_ff <= times_ff[31:16];
            end
            else
              dt_evt_ff <= low_line;
          end
        end
        ST_DEAD:
        begin
          if (tick_ff)
          begin
            if (st_cnt_ff <= 16'h0001)
            begin
              state_ff <= ST_WAITC;
              st_cnt_ff <= `ARLK_WAIT_MS;
            end
            else
              st_cnt_ff <= st_cnt_ff - 16'h0001;
          end
        end
        ST_WAITC:
        begin
          if (close_ok)
          begin
            close_req_ff <= 1'b1;
            state_ff <= ST_CLOSING;
            seen_ff <= 1'b0;
          end
          else if (tick_ff)
          begin
            if (st_cnt_ff <= 16'h0001)
              timeout_ff <= 1'b1;
            else
              st_cnt_ff <= st_cnt_ff - 16'h0001;
          end
        end
        default:
        begin
          if (breaker_close)
            seen_ff <= 1'b1;
          else if (seen_ff & ~fail_evt_ff)
          begin
            // Successful reclose: advance, or after the last shot go to final trip (FTEN set) or lock out.
            state_ff <= ST_IDLE;
            reclaim_cnt_ff <= times_ff[15:0];
            reclaim_run_ff <= 1'b1;
            if (shot_ff >= shots)
              ptr_ff <= ctrl_ff[`ARLK_CTRL_FTEN] ? `ARLK_PTR_FINAL : `ARLK_PTR_LOCK;
            else
              ptr_ff <= shot_ff + 3'h1;
          end
        end
      endcase
      // Aborts and forced lock-outs override the sequence.
      if (abort)
      begin
        state_ff <= ST_IDLE;
        cause_ff <= abort_cause;
      end
      if (abort | lock_level | fail_evt_ff | timeout_ff | man_close_lock)
      begin
        ptr_ff <= `ARLK_PTR_LOCK;
        reclaim_cnt_ff <= times_ff[15:0];
        reclaim_run_ff <= 1'b1;
        if (~abort & man_close_lock)
          cause_ff <= `ARLK_CAUSE_MANCLOSE;
        else if (~abort & maint_zero & lock_level & ~reclose_inhibit_input_s & enable & ~fault_s)
          cause_ff <= `ARLK_CAUSE_MAINT;
      end
    end
  end

endmodule

// File: testbench/arlk_properties.sv
`timescale 1ns/1ps
module arlk_properties #(
  parameter integer TICK_CYCLES = 125000
)
(
  // Clock and reset.
  input wire clk,
  input wire rst_b,
  // Register bus.
  input wire psel,
  input wire penable,
  input wire [7:0] paddr,
  input wire pready,
  input wire pslverr,
  // Pins.
  input wire [3:0] reclose_initiation_lines,
  input wire breaker_open,
  input wire breaker_close,
  input wire breaker_fail_alarm,
  input wire [3:0] definite_trip_alarm
);
  // One ms of slack covers the phase of the time base tick.
  localparam [31:0] ALM_MIN = 199 * TICK_CYCLES;
  localparam [31:0] PUL_MAX = 201 * TICK_CYCLES;
  reg [31:0] dt_ff;
  reg [31:0] op_ff;
  reg [31:0] cl_ff;
  // Count the cycles that any trip alarm, the open and the close output have stayed high.
  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      dt_ff <= 32'h0;
      op_ff <= 32'h0;
      cl_ff <= 32'h0;
    end
    else
    begin
      dt_ff <= (|definite_trip_alarm) ? dt_ff + 32'h1 : 32'h0;
      op_ff <= breaker_open ? op_ff + 32'h1 : 32'h0;
      cl_ff <= breaker_close ? cl_ff + 32'h1 : 32'h0;
    end
  end
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  a_ctrl_exclusive: assert property (!(breaker_open && breaker_close))
    else $error("open and close high together");
  a_deftrip_min: assert property ($fell(|definite_trip_alarm) |-> dt_ff >= ALM_MIN)
    else $error("trip alarm too short");
  a_fail_hold: assert property ($rose(breaker_fail_alarm) |-> breaker_fail_alarm [*8])
    else $error("fail alarm too short");
  a_open_max: assert property (op_ff < PUL_MAX)
    else $error("open pulse too long");
  a_close_max: assert property (cl_ff < PUL_MAX)
    else $error("close pulse too long");
  a_close_lines: assert property ($rose(breaker_close) |->
    ($past(reclose_initiation_lines, 4) == 4'h0))
    else $error("close with a line active");
  a_ready_one: assert property (pready |=> !pready)
    else $error("ready held too long");
  a_ready_lat: assert property ((psel && penable && !$past(penable)) |=> pready)
    else $error("ready late");
  a_slverr_map: assert property ((pready && paddr[1:0] == 2'b00) |-> pslverr == (paddr > 8'h1c))
    else $error("wrong error response");
  c_close: cover property ($rose(breaker_close));
  c_fail: cover property ($rose(breaker_fail_alarm));
  c_trip: cover property ($rose(|definite_trip_alarm));
endmodule

bind arlk_reclose_lockout arlk_properties #(.TICK_CYCLES(TICK_CYCLES)) u_chk (.clk(clk), .rst_b(rst_b),
  .psel(psel), .penable(penable), .paddr(paddr), .pready(pready), .pslverr(pslverr),
  .reclose_initiation_lines(reclose_initiation_lines), .breaker_open(breaker_open),
  .breaker_close(breaker_close), .breaker_fail_alarm(breaker_fail_alarm),
  .definite_trip_alarm(definite_trip_alarm));

// File: testbench/arlk_breaker_model.sv
`timescale 1ns/1ps
module arlk_breaker_model (
  // Clock and control pulses.
  input wire clk,
  input wire open_cmd,
  input wire close_cmd,
  // Protection trip, manual close and a jammed mechanism.
  input wire trip,
  input wire mclose,
  input wire stuck,
  // Position, high when closed.
  output reg pos
);
  // The breaker is closed at power up.
  initial pos = 1'b1;
  // Contacts move a cycle after a command; a jam ignores the relay only.
  always @(posedge clk)
  begin
    if (trip || (open_cmd && !stuck))
      pos <= 1'b0;
    else if (mclose || (close_cmd && !stuck))
      pos <= 1'b1;
  end
endmodule

// File: testbench/arlk_tb.sv
`timescale 1ns/1ps
module tb;
  // Stimulus.
  reg clk = 1'b0;
  reg rst_b = 1'b0;
  reg psel = 1'b0;
  reg penable = 1'b0;
  reg pwrite = 1'b0;
  reg [7:0] paddr = 8'h00;
  reg [31:0] pwdata = 32'h0;
  reg [3:0] lines = 4'h0;
  reg trip = 1'b0;
  reg mclose = 1'b0;
  reg stuck = 1'b0;
  reg inh = 1'b0;
  // Outputs.
  wire [31:0] prdata;
  wire pready;
  wire pslverr;
  wire bopen;
  wire bclose;
  wire bfail;
  wire [3:0] dtrip;
  wire pos;
  // Bookkeeping.
  integer fail_count = 0;
  integer samples_checked = 0;
  integer cyc = 0;
  reg [31:0] rd;
  reg err;
  // A 10 cycle tick keeps every ms figure short.
  arlk_reclose_lockout #(.TICK_CYCLES(10)) u_dut (.clk(clk), .rst_b(rst_b), .ce(1'b1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .reclose_initiation_lines(lines), .breaker_position_input(pos),
    .close_inhibit_input(1'b0), .reclose_inhibit_input(inh), .synchronism_input(1'b0),
    .internal_fault(1'b0), .breaker_open(bopen), .breaker_close(bclose), .breaker_fail_alarm(bfail),
    .definite_trip_alarm(dtrip));
  arlk_breaker_model u_brk (.clk(clk), .open_cmd(bopen), .close_cmd(bclose), .trip(trip),
    .mclose(mclose), .stuck(stuck), .pos(pos));
  // The clock.
  always #4 clk = ~clk;
  // Cut a hang short; the tests need about 7000 cycles.
  always @(posedge clk)
  begin
    cyc = cyc + 1;
    if (cyc == 30000)
    begin
      fail_count = fail_count + 1;
      report_and_stop();
    end
  end
  // Compare and count.
  task check(input string nm, input logic [31:0] exp, input logic [31:0] got);
    begin
      samples_checked = samples_checked + 1;
      if (got !== exp)
      begin
        fail_count = fail_count + 1;
        $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
    end
  endtask
  // One bus transfer; an idle edge follows so signals are never set twice at one edge.
  // The wait has no bound of its own: only the cycle watchdog may end it.
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    begin
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1)
      begin
        @(posedge clk);
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
    end
  endtask
  // Protection trips the breaker while lines are up for 21 cycles.
  task fire(input logic [3:0] l);
    begin
      lines <= l;
      trip <= 1'b1;
      @(posedge clk);
      trip <= 1'b0;
      repeat (20) @(posedge clk);
      lines <= 4'h0;
    end
  endtask
  // Wait, bounded, for close (0) or fail alarm (1).
  task wait_for(input integer sel);
    integer n;
    begin
      n = 0;
      while ((sel == 0 ? bclose : bfail) !== 1'b1 && n < 25000)
      begin
        @(posedge clk);
        n = n + 1;
      end
    end
  endtask
  // Verdict.
  task report_and_stop;
    begin
      $display("checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0)
        $display("Testbench passed");
      else
        $display("Testbench failed");
      $finish;
    end
  endtask
  // Test sequence.
  initial
  begin
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    apb(1'b0, 8'h00, 32'h0);
    check("ctrl", 32'h0000_0001, rd);
    apb(1'b0, 8'h1c, 32'h0);
    check("pointer", 32'h1, {29'h0, rd[2:0]});
    apb(1'b1, 8'h20, 32'h0000_00ff);
    check("slverr", 32'h1, {31'h0, err});
    $display("test registers done");
    // One shot: weight 5, count 12, dead 20 ms, reclaim 50 ms.
    apb(1'b1, 8'h14, 32'h0000_0005);
    apb(1'b1, 8'h18, 32'h0000_000c);
    apb(1'b1, 8'h0c, 32'h0014_0032);
    apb(1'b1, 8'h00, 32'h0000_0103);
    fire(4'h1);
    wait_for(0);
    check("close", 32'h1, {31'h0, bclose});
    repeat (40) @(posedge clk);
    apb(1'b0, 8'h1c, 32'h0);
    check("pointer", 32'h7, {29'h0, rd[2:0]});
    apb(1'b0, 8'h18, 32'h0);
    check("count", 32'h7, {16'h0, rd[15:0]});
    repeat (600) @(posedge clk);
    apb(1'b0, 8'h1c, 32'h0);
    check("pointer", 32'h1, {29'h0, rd[2:0]});
    $display("test reclose done");
    // No shots left: lines 2 and 4 trip, lowest wins.
    apb(1'b1, 8'h00, 32'h0000_0003);
    fire(4'ha);
    check("deftrip", 32'h2, {28'h0, dtrip});
    mclose <= 1'b1;
    @(posedge clk);
    mclose <= 1'b0;
    repeat (2100) @(posedge clk);
    check("deftrip", 32'h0, {28'h0, dtrip});
    $display("test definite trip done");
    // A jammed breaker never closes.
    apb(1'b1, 8'h00, 32'h0000_0103);
    stuck <= 1'b1;
    fire(4'h1);
    wait_for(1);
    check("fail", 32'h1, {31'h0, bfail});
    apb(1'b0, 8'h1c, 32'h0);
    check("cause", 32'h1, {28'h0, rd[15:12]});
    check("pointer", 32'h7, {29'h0, rd[2:0]});
    $display("test breaker fail done");
    // Reclose inhibit holds lock-out past the reclaim time; a full reclaim follows release.
    inh <= 1'b1;
    repeat (700) @(posedge clk);
    apb(1'b0, 8'h1c, 32'h0);
    check("pointer", 32'h7, {29'h0, rd[2:0]});
    check("reclaim", 32'h1, {31'h0, rd[16]});
    inh <= 1'b0;
    repeat (300) @(posedge clk);
    apb(1'b0, 8'h1c, 32'h0);
    check("pointer", 32'h7, {29'h0, rd[2:0]});
    repeat (300) @(posedge clk);
    apb(1'b0, 8'h1c, 32'h0);
    check("pointer", 32'h1, {29'h0, rd[2:0]});
    $display("test reclose inhibit done");
    report_and_stop();
  end
endmodule
